//--- amr_pkg.sv
// Shared constants and types of the converter selection and result block.
// Assumes one system clock and a synchronous, active-high reset.
package amr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CODE_W = 10;
  localparam int SAMPLE_W = 14;
  localparam int CHAN_W = 6;
  localparam int IRQ_W = 2;
  // Register offsets
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h70;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h71;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h72;
  localparam logic [7:0] OFS_RES_LOW = 8'h78;
  localparam logic [7:0] OFS_RES_HIGH = 8'h79;
  localparam logic [7:0] OFS_CONV_CTRL = 8'h7A;
  localparam logic [7:0] OFS_STATUS_B = 8'h7B;
  localparam logic [7:0] OFS_INPUT_SELECT = 8'h7C;
  // Field positions
  localparam int REF_MSB = 7;
  localparam int REF_LSB = 6;
  localparam int LADJ_BIT = 5;
  localparam int MUX_MSB = 4;
  localparam int CHAN_MSB_BIT = 3;
  localparam int START_BIT = 6;
  localparam int DONE_BIT = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_CLIP = 1;
  // Reset values and masks
  localparam logic [7:0] SELECT_RST = 8'h00;
  localparam logic [7:0] STATUS_B_RST = 8'h00;
  localparam logic [7:0] STATUS_B_MASK = 8'h4F;
  localparam logic [1:0] IRQ_RST = 2'h0;
  localparam logic [9:0] RESULT_RST = 10'h000;
  // Result coding
  localparam int SE_SHIFT = 2;
  localparam int DIFF_SHIFT = 3;
  localparam logic [9:0] SE_MAX = 10'h3FF;
  localparam logic [9:0] DIFF_MAX = 10'h1FF;
  localparam logic [9:0] DIFF_MIN = 10'h200;
  // Single-ended channel codes
  localparam logic [1:0] SE_GROUP = 2'h0;
  localparam logic [4:0] SE_BANDGAP = 5'h1E;
  localparam logic [4:0] SE_GROUND = 5'h1F;
  typedef enum logic [1:0] {
    REF_EXT = 2'h0, REF_SUPPLY = 2'h1, REF_1V1 = 2'h2, REF_2V56 = 2'h3
  } amr_ref_t;
  typedef enum logic [1:0] {ST_IDLE = 2'h1, ST_CONV = 2'h2} amr_state_t;
endpackage : amr_pkg

//--- amr_fmt_if.sv
// Bundle between the selection control and the result formatter.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
interface amr_fmt_if;
  logic capture;
  logic differential;
  logic [amr_pkg::SAMPLE_W-1:0] sample;
  logic left_adjust;
  logic [amr_pkg::CODE_W-1:0] code;
  logic clip;
  logic [amr_pkg::DATA_W-1:0] low_byte;
  logic [amr_pkg::DATA_W-1:0] high_byte;
  modport ctrl (output capture, differential, sample, left_adjust,
                input code, clip, low_byte, high_byte);
  modport fmt (input capture, differential, sample, left_adjust,
               output code, clip, low_byte, high_byte);
endinterface : amr_fmt_if

//--- amr_result_fmt.sv
// Scales, saturates, holds and aligns the 10-bit conversion result.
// Assumes the sample is stable in the capture cycle.
`timescale 1ns/100ps
module amr_result_fmt (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Formatter side of the bundle
  amr_fmt_if.fmt fmt
);
  typedef struct packed {
    logic [amr_pkg::CODE_W-1:0] code;
  } amr_fmt_state_t;

  amr_fmt_state_t state_ff;
  amr_fmt_state_t nxt_state;
  logic [amr_pkg::SAMPLE_W-amr_pkg::SE_SHIFT-1:0] se_q;
  logic [amr_pkg::SAMPLE_W-amr_pkg::DIFF_SHIFT-1:0] diff_q;
  logic [amr_pkg::CODE_W-1:0] new_code;
  logic new_clip;

  always_comb begin
    se_q = fmt.sample[amr_pkg::SAMPLE_W-1:amr_pkg::SE_SHIFT];
    diff_q = fmt.sample[amr_pkg::SAMPLE_W-1:amr_pkg::DIFF_SHIFT];
    new_clip = 1'b0;
    new_code = amr_pkg::RESULT_RST;
    if (fmt.differential) begin
      // Top two bits disagree: beyond the 10-bit signed range
      if (diff_q[10] != diff_q[9]) begin
        new_clip = 1'b1;
        new_code = diff_q[10] ? amr_pkg::DIFF_MIN : amr_pkg::DIFF_MAX;
      end else begin
        new_code = diff_q[9:0];
      end
    end else if (|se_q[11:10]) begin
      new_clip = 1'b1;
      new_code = amr_pkg::SE_MAX;
    end else begin
      new_code = se_q[9:0];
    end
    nxt_state = state_ff;
    if (fmt.capture) begin
      nxt_state.code = new_code;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_ff <= '{code: amr_pkg::RESULT_RST};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign fmt.code = state_ff.code;
  assign fmt.clip = new_clip;
  // Alignment follows the live bit, not the one at capture
  assign fmt.high_byte = fmt.left_adjust ? state_ff.code[9:2] : {6'h00, state_ff.code[9:8]};
  assign fmt.low_byte = fmt.left_adjust ? {state_ff.code[1:0], 6'h00} : state_ff.code[7:0];

  se_code_a: assert property (@(posedge sys_clk) disable iff (reset)
    fmt.capture && !fmt.differential && !(|fmt.sample[13:12])
    |=> fmt.code == $past(fmt.sample[11:2]))
    else $error("single-ended code is not the scaled sample");

  diff_clip_a: assert property (@(posedge sys_clk) disable iff (reset)
    fmt.capture && fmt.differential && fmt.sample[13] && !fmt.sample[12]
    |=> fmt.code == amr_pkg::DIFF_MIN)
    else $error("negative overrange does not saturate");

  sign_bit_a: assert property (@(posedge sys_clk) disable iff (reset)
    fmt.capture && fmt.differential |=> fmt.code[9] == $past(fmt.sample[13]))
    else $error("sign bit does not follow the difference");
endmodule : amr_result_fmt

//--- amr_adc_mux_ctrl.sv
// Selection register, deferred channel and reference control, result
// readout and done interrupt of a 10-bit converter.
// Assumes the conversion core runs on sys_clk and pulses conv_done once.
//
// What this block does
// - Finished result lands in result bytes, flag set
// - Single-ended code is input times 1024 over reference
// - Single-ended codes span 0x000 to 0x3FF unsigned
// - Differential code is difference times 512 over reference
// - Differential two's complement, 0x200 to 0x1FF, saturating
// - Result MSB is the differential sign
// - Bits 7:6 pick the reference source
// - Channel and reference writes wait until conversion completes
// - Left-adjust bit 5 left-aligns the result
// - Left-adjust change alters result bytes at once
// - Bits 4:0 pick the channel and gain
// - Extra channel bit, also deferred while converting
//
// Chosen here: strobed register access.
`timescale 1ns/100ps
module amr_adc_mux_ctrl (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Register port
  input wire logic [amr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [amr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [amr_pkg::DATA_W-1:0] reg_rdata,
  // Conversion core
  output logic conv_start,
  output logic [1:0] conv_reference,
  output logic [amr_pkg::CHAN_W-1:0] conv_channel,
  output logic conv_differential,
  output logic conv_busy,
  input wire logic conv_done,
  input wire logic [amr_pkg::SAMPLE_W-1:0] conv_sample,
  // Interrupt
  output logic irq
);
  typedef struct packed {
    amr_pkg::amr_state_t phase;
    logic [7:0] input_select;
    logic [7:0] status_b;
    logic [1:0] act_ref;
    logic [amr_pkg::CHAN_W-1:0] act_chan;
    logic start;
    logic [amr_pkg::IRQ_W-1:0] irq_status;
    logic [amr_pkg::IRQ_W-1:0] irq_enable;
    logic [amr_pkg::DATA_W-1:0] rdata;
  } amr_ctrl_state_t;

  amr_ctrl_state_t state_ff;
  amr_ctrl_state_t nxt_state;
  amr_fmt_if fmt_bus ();

  logic [amr_pkg::CHAN_W-1:0] pending_chan;
  logic busy;
  logic finish;
  logic start_cmd;
  logic [amr_pkg::IRQ_W-1:0] irq_set;
  logic [amr_pkg::IRQ_W-1:0] irq_clr;

  // Differential when outside the plain input group and the two fixed sources
  function automatic logic chan_is_diff(input logic [amr_pkg::CHAN_W-1:0] chan);
    logic plain;
    plain = (chan[4:3] == amr_pkg::SE_GROUP) || (chan[4:0] == amr_pkg::SE_BANDGAP)
            || (chan[4:0] == amr_pkg::SE_GROUND);
    return !plain;
  endfunction : chan_is_diff

  assign busy = (state_ff.phase == amr_pkg::ST_CONV);
  assign finish = busy && conv_done;
  assign pending_chan = {state_ff.status_b[amr_pkg::CHAN_MSB_BIT],
                         state_ff.input_select[amr_pkg::MUX_MSB:0]};
  assign start_cmd = reg_write && (reg_addr == amr_pkg::OFS_CONV_CTRL)
                     && reg_wdata[amr_pkg::START_BIT];

  always_comb begin
    irq_set = '0;
    irq_set[amr_pkg::IRQ_DONE] = finish;
    irq_set[amr_pkg::IRQ_CLIP] = finish && fmt_bus.clip;
    irq_clr = '0;
    if (reg_write && (reg_addr == amr_pkg::OFS_IRQ_CLEAR)) begin
      irq_clr = reg_wdata[amr_pkg::IRQ_W-1:0];
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_state.start = 1'b0;
    // Register writes; channel and reference take effect only through act_* below
    if (reg_write && (reg_addr == amr_pkg::OFS_INPUT_SELECT)) begin
      nxt_state.input_select = reg_wdata;
    end
    if (reg_write && (reg_addr == amr_pkg::OFS_STATUS_B)) begin
      nxt_state.status_b = reg_wdata & amr_pkg::STATUS_B_MASK;
    end
    if (reg_write && (reg_addr == amr_pkg::OFS_IRQ_ENABLE)) begin
      nxt_state.irq_enable = reg_wdata[amr_pkg::IRQ_W-1:0];
    end
    // Set wins over a clear in the same cycle
    nxt_state.irq_status = (state_ff.irq_status & ~irq_clr) | irq_set;
    unique case (state_ff.phase)
      amr_pkg::ST_IDLE: begin
        // Only an idle converter picks up a new selection
        nxt_state.act_ref = state_ff.input_select[amr_pkg::REF_MSB:amr_pkg::REF_LSB];
        nxt_state.act_chan = pending_chan;
        if (start_cmd) begin
          nxt_state.phase = amr_pkg::ST_CONV;
          nxt_state.start = 1'b1;
        end
      end
      amr_pkg::ST_CONV: begin
        // Old setting is held; a start request here is dropped
        if (conv_done) begin
          nxt_state.phase = amr_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state.phase = amr_pkg::ST_IDLE;
      end
    endcase
    // Read data stand only in the cycle after the strobe
    nxt_state.rdata = '0;
    if (reg_read) begin
      case (reg_addr)
        amr_pkg::OFS_INPUT_SELECT: nxt_state.rdata = state_ff.input_select;
        amr_pkg::OFS_STATUS_B: nxt_state.rdata = state_ff.status_b;
        amr_pkg::OFS_RES_LOW: nxt_state.rdata = fmt_bus.low_byte;
        amr_pkg::OFS_RES_HIGH: nxt_state.rdata = fmt_bus.high_byte;
        amr_pkg::OFS_IRQ_STATUS: nxt_state.rdata[amr_pkg::IRQ_W-1:0] = state_ff.irq_status;
        amr_pkg::OFS_IRQ_ENABLE: nxt_state.rdata[amr_pkg::IRQ_W-1:0] = state_ff.irq_enable;
        amr_pkg::OFS_CONV_CTRL: begin
          nxt_state.rdata[amr_pkg::START_BIT] = busy;
          nxt_state.rdata[amr_pkg::DONE_BIT] = state_ff.irq_status[amr_pkg::IRQ_DONE];
        end
        default: nxt_state.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_ff <= '{
        phase: amr_pkg::ST_IDLE,
        input_select: amr_pkg::SELECT_RST,
        status_b: amr_pkg::STATUS_B_RST,
        act_ref: amr_pkg::REF_EXT,
        act_chan: '0,
        start: 1'b0,
        irq_status: amr_pkg::IRQ_RST,
        irq_enable: amr_pkg::IRQ_RST,
        rdata: '0
      };
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Formatter hookup
  assign fmt_bus.capture = finish;
  assign fmt_bus.differential = chan_is_diff(state_ff.act_chan);
  assign fmt_bus.sample = conv_sample;
  // Live bit, so a change re-aligns the bytes at once
  assign fmt_bus.left_adjust = state_ff.input_select[amr_pkg::LADJ_BIT];

  amr_result_fmt u_fmt (
    .sys_clk (sys_clk),
    .reset (reset),
    .fmt (fmt_bus.fmt)
  );

  // Outputs
  assign reg_rdata = state_ff.rdata;
  assign conv_start = state_ff.start;
  assign conv_reference = state_ff.act_ref;
  assign conv_channel = state_ff.act_chan;
  assign conv_differential = fmt_bus.differential;
  assign conv_busy = busy;
  assign irq = |(state_ff.irq_status & state_ff.irq_enable);

  // Checks
  default clocking chk_cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  sequence conv_finish_s;
    busy && conv_done;
  endsequence

  sequence select_write_busy_s;
    busy && !conv_done && reg_write
    && ((reg_addr == amr_pkg::OFS_INPUT_SELECT) || (reg_addr == amr_pkg::OFS_STATUS_B));
  endsequence

  done_set_a: assert property (
    conv_finish_s |=> state_ff.irq_status[amr_pkg::IRQ_DONE] && !conv_busy)
    else $error("done flag not set after conversion end");

  done_wins_a: assert property (
    conv_finish_s and (reg_write && (reg_addr == amr_pkg::OFS_IRQ_CLEAR)
                       && reg_wdata[amr_pkg::IRQ_DONE])
    |=> state_ff.irq_status[amr_pkg::IRQ_DONE])
    else $error("clear beat a simultaneous done");

  idle_route_a: assert property (
    !busy |=> conv_channel == $past(pending_chan)
              && conv_reference == $past(state_ff.input_select[7:6]))
    else $error("idle converter not following the selection");

  hold_setting_a: assert property (
    busy && !conv_done |=> $stable(conv_reference) && $stable(conv_channel))
    else $error("selection changed during a conversion");

  msb_defer_a: assert property (
    select_write_busy_s ##1 (busy && !conv_done)
    |=> conv_channel[5] == $past(conv_channel[5], 2))
    else $error("channel msb applied mid conversion");

  apply_after_a: assert property (
    conv_finish_s ##1 !reg_write |=> conv_channel == $past(pending_chan))
    else $error("new selection not applied after completion");

  start_ignore_a: assert property (
    busy && start_cmd |=> !conv_start)
    else $error("start accepted while converting");

  start_pulse_a: assert property (
    !busy && start_cmd |=> conv_start && conv_busy ##1 !conv_start)
    else $error("start not a one-cycle pulse");

  left_read_a: assert property (
    reg_read && (reg_addr == amr_pkg::OFS_RES_HIGH) && fmt_bus.left_adjust
    |=> reg_rdata == $past(fmt_bus.code[9:2]))
    else $error("left-adjusted high byte wrong");

  right_read_a: assert property (
    reg_read && (reg_addr == amr_pkg::OFS_RES_LOW) && !fmt_bus.left_adjust
    |=> reg_rdata == $past(fmt_bus.code[7:0]))
    else $error("right-adjusted low byte wrong");

  unmapped_read_a: assert property (
    reg_read && (reg_addr == 8'h00) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule : amr_adc_mux_ctrl

//--- amr_core_model.sv
// Conversion core model: start, programmable delay, one done pulse.
// Assumes sys_clk is shared with the block; the bench sets delay and sample.
`timescale 1ns/100ps
module amr_core_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // From the block
  input wire logic conv_start,
  input wire logic [1:0] conv_reference,
  input wire logic [5:0] conv_channel,
  // To the block
  output logic conv_done,
  output logic [13:0] conv_sample,
  // Bench side
  input wire logic [7:0] delay,
  input wire logic [13:0] next_sample,
  output logic sel_moved,
  output logic [7:0] start_count
);
  logic busy_ff;
  logic [7:0] left_ff;
  logic [7:0] held_ff;
  always @(posedge sys_clk) begin
    conv_done <= 1'b0;
    // Sample only valid with done, so it toggles otherwise
    conv_sample <= ~conv_sample;
    if (conv_start) start_count <= start_count + 8'h01;
    if (reset) begin
      busy_ff <= 1'b0;
      sel_moved <= 1'b0;
      start_count <= 8'h00;
      conv_sample <= 14'h0000;
    end else if (busy_ff) begin
      if (held_ff !== {conv_reference, conv_channel}) sel_moved <= 1'b1;
      if (left_ff == 8'h00) begin
        busy_ff <= 1'b0;
        conv_done <= 1'b1;
        conv_sample <= next_sample;
      end else begin
        left_ff <= left_ff - 8'h01;
      end
    end else if (conv_start) begin
      busy_ff <= 1'b1;
      left_ff <= delay;
      held_ff <= {conv_reference, conv_channel};
    end
  end
endmodule : amr_core_model

//--- adc_mux_result_format_tb.sv
// Self-checking bench of the converter selection and result block.
// Assumes package, bundle, design and core model compile first.
`timescale 1ns/100ps
module adc_mux_result_format_tb;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] delay = 8'h00;
  logic [13:0] next_sample = 14'h0000;
  logic [7:0] reg_rdata, start_count;
  logic [13:0] conv_sample;
  logic [5:0] conv_channel;
  logic [1:0] conv_reference;
  logic conv_start, conv_differential, conv_busy, conv_done, irq, sel_moved;
  logic [31:0] seed = 32'h0000_0050;
  logic [9:0] last_code = 10'h000;
  logic [7:0] addrs[10] = '{8'h7C, 8'h7B, 8'h7A, 8'h78, 8'h79, 8'h70, 8'h71, 8'h72, 8'h73,
    8'h00};
  logic [5:0] ch_t[8] = '{6'h00, 6'h07, 6'h1F, 6'h1E, 6'h10, 6'h2D, 6'h1D, 6'h0B};
  logic [13:0] s_t[8] = '{14'h0000, 14'h0FFF, 14'h1000, 14'h3FFF, 14'h0FF8, 14'h1000,
    14'h2000, 14'h3000};
  int code_q[$];
  int err_count = 0;
  int check_count = 0;
  int cycles = 0;

  always #20 sys_clk = ~sys_clk;

  amr_adc_mux_ctrl DUT (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .conv_start(conv_start), .conv_reference(conv_reference), .conv_channel(conv_channel),
    .conv_differential(conv_differential), .conv_busy(conv_busy), .conv_done(conv_done),
    .conv_sample(conv_sample), .irq(irq));
  amr_core_model core (.sys_clk(sys_clk), .reset(reset), .conv_start(conv_start),
    .conv_reference(conv_reference), .conv_channel(conv_channel), .conv_done(conv_done),
    .conv_sample(conv_sample), .delay(delay), .next_sample(next_sample),
    .sel_moved(sel_moved), .start_count(start_count));

  task automatic complete_run;
    if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // Integer reference: scale, then clamp to the code range
  function automatic int code_of(input logic [13:0] s, input logic d, output logic clip);
    int v;
    int hi;
    hi = d ? 511 : 1023;
    if (d) v = $signed(s) >>> 3;
    else v = s >> 2;
    clip = v > hi || v < -512;
    if (v > hi) v = hi;
    if (v < -512) v = -512;
    return v & 1023;
  endfunction : code_of

  function automatic logic is_diff(input logic [5:0] c);
    return c[4:3] != 2'h0 && c[4:0] < 5'h1E;
  endfunction : is_diff

  function automatic logic [15:0] lay(input logic [9:0] c, input logic la);
    return la ? {c, 6'h00} : {6'h00, c};
  endfunction : lay

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask : rd_chk

  task automatic convert(input int i);
    logic [31:0] r;
    logic [13:0] s;
    logic [7:0] hi, lo;
    logic [5:0] ch;
    logic [1:0] rf, en;
    logic la, clip, d, mid;
    int code;
    r = xs();
    ch = i < 8 ? ch_t[i] : r[5:0];
    s = i < 8 ? s_t[i] : r[29:16];
    la = r[6];
    en = r[9:8];
    d = is_diff(ch);
    mid = i % 4 != 0;
    // No external drive on the reference pin; gain pairs use 2.56 V
    rf = d ? 2'h3 : (i < 4 ? 2'(i) : r[31:30]);
    delay <= mid ? 8'h18 + {3'h0, r[14:10]} : 8'h00;
    next_sample <= s;
    code_q.push_back(code_of(s, d, clip));
    wr(8'h7B, {4'h0, ch[5], 3'h0});
    wr(8'h7C, {rf, la, ch[4:0]});
    wr(8'h72, {6'h00, en});
    rd_chk(8'h7C, {rf, la, ch[4:0]});
    chk(conv_reference, rf);
    chk(conv_channel, ch);
    chk(conv_differential, d);
    wr(8'h7A, 8'h40);
    // Clear lands in the done cycle; the set must survive it
    if (!mid) begin
      @(posedge sys_clk);
      wr(8'h71, 8'h01);
    end
    if (mid) begin
      la = ~la;
      wr(8'h7C, {rf, la, ~ch[4:0]});
      wr(8'h7B, {4'h0, ~ch[5], 3'h0});
      wr(8'h7A, 8'h40);
      rd_chk(8'h7A, 8'h40);
      chk(conv_channel, ch);
      rd(8'h79, hi);
      rd(8'h78, lo);
      chk({hi, lo}, lay(last_code, la));
      ch = ~ch;
    end
    for (int k = 0; k < 100 && conv_done !== 1'b1; k++) @(negedge sys_clk);
    repeat (2) @(negedge sys_clk);
    chk(conv_busy, 1'b0);
    chk(conv_channel, ch);
    chk(sel_moved, 1'b0);
    chk(start_count, 16'(i + 1));
    code = code_q.pop_front();
    rd(8'h79, hi);
    rd(8'h78, lo);
    chk({hi, lo}, lay(10'(code), la));
    rd_chk(8'h70, {6'h00, clip, 1'b1});
    chk(irq, |({clip, 1'b1} & en));
    rd_chk(8'h7A, 8'h10);
    wr(8'h71, 8'h03);
    rd_chk(8'h70, 8'h00);
    chk(irq, 1'b0);
    last_code = 10'(code);
  endtask : convert

  // Cut a hang short well past the longest expected run
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    chk({conv_start, conv_busy, irq, conv_reference, conv_channel}, 16'h0000);
    foreach (addrs[k]) rd_chk(addrs[k], 8'h00);
    wr(8'h7B, 8'hFF);
    wr(8'h78, 8'hFF);
    rd_chk(8'h7B, 8'h4F);
    rd_chk(8'h78, 8'h00);
    for (int i = 0; i < 40; i++) convert(i);
    complete_run();
  end
endmodule : adc_mux_result_format_tb
